//--- verilog/boundary_scan_instruction_logic.sv
// boundary scan instruction logic with its pin snapshot fifo
// assumes tck, tms, tdi arrive asynchronously and the snapshot
// source runs on clk_i
`timescale 1ns/1ps
`include "bsc_cfg.svh"

// =====================================================================
// snapshot fifo
module bsc_snap_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = `BSC_FIFO_D
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   localparam int unsigned CW = $clog2(D + 1);
   localparam logic [CW-1:0] DEPTH = CW'(D);

   logic [W-1:0]  mem_r [D];   // storage in flip-flops
   logic [W-1:0]  mem_nxt [D];
   logic [AW-1:0] wp_r, wp_nxt; // write index
   logic [AW-1:0] rp_r, rp_nxt; // read index
   logic [CW-1:0] cnt_r, cnt_nxt; // words held
   logic          ready_r, ready_nxt; // registered so ready is a flop
   logic          push, pop;

   assign in_ready_o  = ready_r;
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rp_r];

   // pointer step with wrap, used by both ends
   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : step

   // next state of the fifo
   always_comb begin
      push    = ce_i & in_valid_i & ready_r;
      pop     = ce_i & out_valid_o & out_ready_i;
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data_i;
         wp_nxt        = step(wp_r);
      end
      if (pop) begin
         rp_nxt = step(rp_r);
      end
      if (push && !pop) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
      ready_nxt = (cnt_nxt != DEPTH);
   end

   // register only
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wp_r   <= '0;
         rp_r   <= '0;
         cnt_r  <= '0;
         ready_r <= 1'b1;
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         mem_r  <= mem_nxt;
         wp_r   <= wp_nxt;
         rp_r   <= rp_nxt;
         cnt_r  <= cnt_nxt;
         ready_r <= ready_nxt;
      end
   end

endmodule : bsc_snap_fifo

// =====================================================================
// test access port with instruction, bypass, id and boundary registers
module boundary_scan_instruction_logic #(
   parameter int unsigned BSR_W    = `BSC_BSR_W,
   parameter int unsigned FIFO_D   = `BSC_FIFO_D,
   parameter logic [31:0] ID_VALUE = `BSC_ID_VALUE
) (
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic               ce_i,
   input  wire bsc_pkg::tap_pins_s jtag_i,
   output logic                    tdo_o,
   output logic                    tdo_oe_o,
   input  wire logic [BSR_W-2:0]   snap_data_i,
   input  wire logic               snap_valid_i,
   output logic                    snap_ready_o,
   output logic [BSR_W-2:0]        pin_drive_o,
   output logic                    extest_o,
   output logic                    q_bus_en_o,
   output logic [2:0]              instr_o
);
   localparam int unsigned CELL = BSR_W - 1; // output bus enable cell
   localparam logic [BSR_W-1:0] UPD_PRESET = {1'b1, {(BSR_W-1){1'b0}}};

   // =================================================================
   // state
   bsc_pkg::tap_pins_s   pm_r, ps_r;     // two-stage synchroniser
   logic                 tck_d_r;        // delayed tck for edges
   bsc_pkg::tap_state_e  st_r, st_nxt;   // controller state
   logic [2:0]           ir_r, ir_nxt;   // current instruction
   logic [2:0]           irs_r, irs_nxt; // instruction shift stage
   logic                 byp_r, byp_nxt; // bypass stage
   logic [31:0]          id_r, id_nxt;   // id shift stage
   logic [BSR_W-1:0]     bsr_r, bsr_nxt; // boundary shift stage
   logic [BSR_W-1:0]     upd_r, upd_nxt; // boundary preload stage
   logic                 tdo_nxt, oe_nxt;
   logic                 ext_nxt, qen_nxt;
   logic [BSR_W-2:0]     pin_nxt;
   logic [2:0]           ones_r, ones_nxt; // tms-high edge count
   logic                 rise, fall;
   logic [BSR_W-2:0]     fifo_data;
   logic                 fifo_valid, fifo_pop;

   assign rise     = ps_r.tck & ~tck_d_r;
   assign fall     = ~ps_r.tck & tck_d_r;
   assign fifo_pop = rise & (st_r == bsc_pkg::CAP_DR) & uses_bsr(ir_r);

   // snapshots wait here until a capture takes the oldest one
   bsc_snap_fifo #(.W(BSR_W - 1), .D(FIFO_D)) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .ce_i        (ce_i),
      .in_data_i   (snap_data_i),
      .in_valid_i  (snap_valid_i),
      .in_ready_o  (snap_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // =================================================================
   // decode helpers
   // reserved codes fall to bypass so the chain stays one bit long
   function automatic logic uses_bsr(input logic [2:0] op);
      uses_bsr = (op == `BSC_OP_EXTEST) || (op == `BSC_OP_FLOAT) ||
                 (op == `BSC_OP_SAMPLE);
   endfunction : uses_bsr

   function automatic bsc_pkg::tap_state_e next_st(
      input bsc_pkg::tap_state_e s, input logic m);
      case (s)
         bsc_pkg::TLR:    next_st = m ? bsc_pkg::TLR    : bsc_pkg::RTI;
         bsc_pkg::RTI:    next_st = m ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
         bsc_pkg::SEL_DR: next_st = m ? bsc_pkg::SEL_IR : bsc_pkg::CAP_DR;
         bsc_pkg::CAP_DR: next_st = m ? bsc_pkg::EX1_DR : bsc_pkg::SH_DR;
         bsc_pkg::SH_DR:  next_st = m ? bsc_pkg::EX1_DR : bsc_pkg::SH_DR;
         bsc_pkg::EX1_DR: next_st = m ? bsc_pkg::UPD_DR : bsc_pkg::PAU_DR;
         bsc_pkg::PAU_DR: next_st = m ? bsc_pkg::EX2_DR : bsc_pkg::PAU_DR;
         bsc_pkg::EX2_DR: next_st = m ? bsc_pkg::UPD_DR : bsc_pkg::SH_DR;
         bsc_pkg::UPD_DR: next_st = m ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
         bsc_pkg::SEL_IR: next_st = m ? bsc_pkg::TLR    : bsc_pkg::CAP_IR;
         bsc_pkg::CAP_IR: next_st = m ? bsc_pkg::EX1_IR : bsc_pkg::SH_IR;
         bsc_pkg::SH_IR:  next_st = m ? bsc_pkg::EX1_IR : bsc_pkg::SH_IR;
         bsc_pkg::EX1_IR: next_st = m ? bsc_pkg::UPD_IR : bsc_pkg::PAU_IR;
         bsc_pkg::PAU_IR: next_st = m ? bsc_pkg::EX2_IR : bsc_pkg::PAU_IR;
         bsc_pkg::EX2_IR: next_st = m ? bsc_pkg::UPD_IR : bsc_pkg::SH_IR;
         bsc_pkg::UPD_IR: next_st = m ? bsc_pkg::SEL_DR : bsc_pkg::RTI;
         default:         next_st = bsc_pkg::TLR;
      endcase
   endfunction : next_st

   // =================================================================
   // next values of the whole port
   always_comb begin
      st_nxt   = st_r;
      ir_nxt   = ir_r;
      irs_nxt  = irs_r;
      byp_nxt  = byp_r;
      id_nxt   = id_r;
      bsr_nxt  = bsr_r;
      upd_nxt  = upd_r;
      tdo_nxt  = tdo_o;
      oe_nxt   = tdo_oe_o;
      ones_nxt = ones_r;
      ext_nxt  = (ir_r == `BSC_OP_EXTEST);
      // the enable cell only matters under external test
      if (ir_r == `BSC_OP_EXTEST) begin
         qen_nxt = upd_r[CELL];
      end else begin
         qen_nxt = (ir_r != `BSC_OP_FLOAT);
      end
      pin_nxt = upd_r[BSR_W-2:0];
      // actions on a rising test clock, chosen by the present state
      if (rise) begin
         st_nxt = next_st(st_r, ps_r.tms);
         // count tms-high rises, a low one clears the count
         ones_nxt = !ps_r.tms ? 3'h0 : (ones_r == `BSC_TLR_EDGES) ? ones_r
                    : 3'(ones_r + 1'b1);
         case (st_r)
            bsc_pkg::CAP_IR: begin
               irs_nxt = {1'b0, `BSC_IR_CAPTURE};
            end
            bsc_pkg::SH_IR: begin
               irs_nxt = {ps_r.tdi, irs_r[2:1]};
            end
            bsc_pkg::UPD_IR: begin
               ir_nxt = irs_r;
            end
            bsc_pkg::CAP_DR: begin
               byp_nxt = 1'b0;
               id_nxt  = ID_VALUE;
               // a fresh snapshot is taken if one waits, else the pins
               bsr_nxt = {upd_r[CELL],
                          fifo_valid ? fifo_data : snap_data_i};
            end
            bsc_pkg::SH_DR: begin
               byp_nxt = ps_r.tdi;
               id_nxt  = {ps_r.tdi, id_r[31:1]};
               // old bits leave at the lsb as new ones enter the msb
               bsr_nxt = {ps_r.tdi, bsr_r[BSR_W-1:1]};
            end
            bsc_pkg::UPD_DR: begin
               if ((ir_r == `BSC_OP_SAMPLE) ||
                   (ir_r == `BSC_OP_EXTEST)) begin
                  upd_nxt = bsr_r;
               end
            end
            default: ;
         endcase
      end
      // reset state holds the defaults for as long as it lasts
      if (st_r == bsc_pkg::TLR) begin
         ir_nxt        = `BSC_OP_IDCODE;
         upd_nxt[CELL] = 1'b1;
      end
      // tdo moves on the falling edge so the far end samples it safely
      if (fall) begin
         oe_nxt = (st_r == bsc_pkg::SH_IR) || (st_r == bsc_pkg::SH_DR);
         if (st_r == bsc_pkg::SH_IR) begin
            tdo_nxt = irs_r[0];
         end else if (ir_r == `BSC_OP_IDCODE) begin
            tdo_nxt = id_r[0];
         end else if (uses_bsr(ir_r)) begin
            tdo_nxt = bsr_r[0];
         end else begin
            tdo_nxt = byp_r;
         end
      end
   end

   // =================================================================
   // registers; ce_i low freezes everything
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pm_r        <= '0;
         ps_r        <= '0;
         tck_d_r     <= 1'b0;
         st_r        <= bsc_pkg::TLR;
         ir_r        <= `BSC_OP_IDCODE;
         irs_r       <= '0;
         byp_r       <= 1'b0;
         id_r        <= '0;
         bsr_r       <= '0;
         upd_r       <= UPD_PRESET;
         tdo_o       <= 1'b0;
         tdo_oe_o    <= 1'b0;
         extest_o    <= 1'b0;
         q_bus_en_o  <= 1'b1;
         pin_drive_o <= '0;
         instr_o     <= `BSC_OP_IDCODE;
         ones_r      <= '0;
      end else if (ce_i) begin
         pm_r        <= jtag_i;
         ps_r        <= pm_r;
         tck_d_r     <= ps_r.tck;
         st_r        <= st_nxt;
         ir_r        <= ir_nxt;
         irs_r       <= irs_nxt;
         byp_r       <= byp_nxt;
         id_r        <= id_nxt;
         bsr_r       <= bsr_nxt;
         upd_r       <= upd_nxt;
         tdo_o       <= tdo_nxt;
         tdo_oe_o    <= oe_nxt;
         extest_o    <= ext_nxt;
         q_bus_en_o  <= qen_nxt;
         pin_drive_o <= pin_nxt;
         instr_o     <= ir_r;
         ones_r      <= ones_nxt;
      end
   end

   // =================================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_tms_reset;
      (ones_r == `BSC_TLR_EDGES) |-> (st_r == bsc_pkg::TLR);
   endproperty
   a_tms_reset: assert property (p_tms_reset)
      else $error("five tms-high edges did not reach reset state");
   property p_tlr_idcode;
      (ce_i && st_r == bsc_pkg::TLR) |=> (ir_r == `BSC_OP_IDCODE);
   endproperty
   a_tlr_idcode: assert property (p_tlr_idcode)
      else $error("instruction not identification after reset state");
   property p_ir_change;
      $changed(ir_r) |-> ($past(st_r) == bsc_pkg::UPD_IR ||
                          $past(st_r) == bsc_pkg::TLR);
   endproperty
   a_ir_change: assert property (p_ir_change)
      else $error("instruction changed outside update or reset");
   property p_cap_ir;
      (ce_i && rise && st_r == bsc_pkg::CAP_IR)
         |=> (irs_r[1:0] == `BSC_IR_CAPTURE);
   endproperty
   a_cap_ir: assert property (p_cap_ir)
      else $error("capture-ir pattern missing");
   property p_id_cap;
      (ce_i && rise && st_r == bsc_pkg::CAP_DR) |=> (id_r == ID_VALUE);
   endproperty
   a_id_cap: assert property (p_id_cap)
      else $error("identification value not captured");
   property p_bypass;
      (ce_i && rise && st_r == bsc_pkg::SH_DR) |=> (byp_r == $past(ps_r.tdi));
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass stage did not take tdi");
   property p_bus_en;
      (ce_i && ir_r == `BSC_OP_EXTEST && !$changed(ir_r))
         |=> (q_bus_en_o == $past(upd_r[CELL]));
   endproperty
   a_bus_en: assert property (p_bus_en)
      else $error("output bus enable does not follow the cell");

   property p_float;
      (ce_i && ir_r == `BSC_OP_FLOAT) |=> !q_bus_en_o;
   endproperty
   a_float: assert property (p_float)
      else $error("memory outputs not floated");

   property p_cell_preset;
      (ce_i && st_r == bsc_pkg::TLR) |=> upd_r[CELL];
   endproperty
   a_cell_preset: assert property (p_cell_preset)
      else $error("enable cell not preset in reset state");

   property p_tdo_fall;
      $changed(tdo_o) |-> $past(fall);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("tdo moved without a falling test clock");

   property p_snapshot;
      (ce_i && fifo_pop && fifo_valid)
         |=> (bsr_r[BSR_W-2:0] == $past(fifo_data));
   endproperty
   a_snapshot: assert property (p_snapshot)
      else $error("capture did not take the waiting snapshot");

endmodule : boundary_scan_instruction_logic

//--- verilog/bsc_cfg.svh
// constants for the boundary scan instruction logic of the memory
// assumes it is included by bare name from the package and the design
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// =====================================================================
// instruction register
`define BSC_IR_W          3
`define BSC_OP_EXTEST     3'h0
`define BSC_OP_IDCODE     3'h1
`define BSC_OP_FLOAT      3'h2
`define BSC_OP_SAMPLE     3'h4
`define BSC_OP_BYPASS     3'h7
`define BSC_IR_CAPTURE    2'h1

// =====================================================================
// data registers
`define BSC_BSR_W         89
`define BSC_ID_W          32
// identification value is arbitrary; bit 0 marks a present id register
`define BSC_ID_VALUE      32'h0a5a_3001
`define BSC_FIFO_D        8

// =====================================================================
// helper figures
`define BSC_TLR_EDGES     3'h5
`define BSC_SYNC_ONE      1'h1

`endif

//--- verilog/bsc_pkg.sv
// types shared by the boundary scan instruction logic
// assumes bsc_cfg.svh sits in the include path
`include "bsc_cfg.svh"

package bsc_pkg;

   // =================================================================
   // controller states, sixteen of them
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_state_e;

   // =================================================================
   // the three test inputs travel together
   typedef struct packed {
      logic tck;   // test clock level
      logic tms;   // mode select
      logic tdi;   // serial data in
   } tap_pins_s;

endpackage : bsc_pkg

//--- tb/jtag_ctl_model.sv
// board-side test controller model: drives tck, tms, tdi, collects tdo
// assumes the bench calls one task at a time; tck idles low between frames
`timescale 1ns/1ps

module jtag_ctl_model (
   input  wire logic          tdo_i,
   output bsc_pkg::tap_pins_s jtag_o,
   output logic [95:0]        res_o,
   output logic [7:0]         res_cnt_o
);

   // =================================================================
   // idle levels
   // tck stands still outside frames; tms and tdi start at pull-up level
   initial begin
      jtag_o    = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      res_o     = '0;
      res_cnt_o = '0;
   end

   // =================================================================
   // one tck period of 125 ns, unrelated in phase to clk_i
   // tms and tdi change while tck is low, tdo is taken at the rise
   task automatic tick(input logic tms, input logic tdi,
                       output logic tdo);
      // non-blocking so a change on a clk_i edge never races the sync
      jtag_o.tms <= tms;
      jtag_o.tdi <= tdi;
      #62.5;
      jtag_o.tck <= 1'b1;
      tdo        = tdo_i;
      #62.5;
      jtag_o.tck <= 1'b0;
   endtask : tick

   // =================================================================
   // five tms-high rises, then park in run-test-idle
   task automatic reset_tap;
      logic t;
      repeat (5) tick(1'b1, 1'b1, t);
      tick(1'b0, 1'b1, t);
   endtask : reset_tap

   // =================================================================
   // full scan from run-test-idle back to run-test-idle
   // lsb goes first; the last bit leaves shift with tms high
   task automatic scan(input logic is_ir, input int n,
                       input logic [95:0] din);
      logic        t;
      logic [95:0] q;
      q = '0;
      tick(1'b1, 1'b1, t);
      if (is_ir)
         tick(1'b1, 1'b1, t);
      tick(1'b0, 1'b1, t);
      tick(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], t);
         q[i] = t;
      end
      tick(1'b1, 1'b1, t);
      tick(1'b0, 1'b1, t);
      res_o     = q;
      res_cnt_o = res_cnt_o + 8'h01;
   endtask : scan

endmodule : jtag_ctl_model

//--- tb/boundary_scan_instruction_logic_bench.sv
// self-checking bench for the boundary scan instruction logic
// assumes jtag_ctl_model drives the link; expected scan results are queued
`timescale 1ns/1ps

module boundary_scan_instruction_logic_bench;

   // arbitrary identification value, bit 0 set
   localparam logic [31:0] ID = 32'h5a3c_0f01;

   logic               clk_i        = 1'b0;
   logic               reset_i      = 1'b1;
   logic               ce_i         = 1'b1;
   bsc_pkg::tap_pins_s jtag;
   logic               tdo_o;
   logic               tdo_oe_o;
   logic               tdo_w;
   logic [87:0]        snap_data_i  = '0;
   logic               snap_valid_i = 1'b0;
   logic               snap_ready_o;
   logic [87:0]        pin_drive_o;
   logic               extest_o;
   logic               q_bus_en_o;
   logic [2:0]         instr_o;
   logic [95:0]        res;
   logic [7:0]         res_cnt;
   int                 mismatches   = 0;
   int                 check_count  = 0;
   logic [95:0]        exp_q[$];    // expected scan results, oldest first
   logic [87:0]        wq[$];       // snapshot words accepted by the fifo

   // =================================================================
   // clock, 100 MHz
   always #5 clk_i = ~clk_i;

   // undriven tdo floats so a stray sample can never match
   assign tdo_w = tdo_oe_o ? tdo_o : 1'bz;

   boundary_scan_instruction_logic #(.ID_VALUE(ID)) i_dut (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .ce_i         (ce_i),
      .jtag_i       (jtag),
      .tdo_o        (tdo_o),
      .tdo_oe_o     (tdo_oe_o),
      .snap_data_i  (snap_data_i),
      .snap_valid_i (snap_valid_i),
      .snap_ready_o (snap_ready_o),
      .pin_drive_o  (pin_drive_o),
      .extest_o     (extest_o),
      .q_bus_en_o   (q_bus_en_o),
      .instr_o      (instr_o)
   );

   jtag_ctl_model i_ctl (
      .tdo_i     (tdo_w),
      .jtag_o    (jtag),
      .res_o     (res),
      .res_cnt_o (res_cnt)
   );

   // =================================================================
   // comparison and closing
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h",
                  $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // watcher: each finished scan is matched against the oldest note
   always @(res_cnt) begin
      if (res_cnt !== 8'h00) begin
         // an unplanned result always counts as a mismatch
         if (exp_q.size() > 0)
            check(res, exp_q.pop_front());
         else
            check(96'h0, 96'h1);
      end
   end

   // =================================================================
   // scan wrappers: note the expectation, scan, let outputs settle
   task automatic ir(input logic [2:0] code);
      exp_q.push_back(96'h1);
      i_ctl.scan(1'b1, 3, 96'(code));
      repeat (2) @(posedge clk_i);
   endtask : ir

   task automatic dr(input int n, input logic [95:0] din,
                     input logic [95:0] exp);
      exp_q.push_back(exp);
      i_ctl.scan(1'b0, n, din);
      repeat (2) @(posedge clk_i);
   endtask : dr

   task automatic idle_checks;
      check(96'(instr_o), 96'h1);
      check(96'(q_bus_en_o), 96'h1);
      check(96'(extest_o), 96'h0);
      check(96'(tdo_oe_o), 96'h0);
   endtask : idle_checks

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      finish_test();
   end

   // =================================================================
   // main sequence
   initial begin
      logic [2:0]  code;
      logic [95:0] d;
      logic [87:0] pat;
      logic        c89;
      void'($urandom(32'h6c763a0a));
      d   = {$urandom, $urandom, $urandom};
      pat = d[87:0];
      repeat (4) @(posedge clk_i);
      reset_i     <= 1'b0;
      snap_data_i <= pat;
      @(posedge clk_i);
      idle_checks();
      i_ctl.reset_tap();
      dr(32, {$urandom, $urandom, $urandom}, 96'(ID));
      // every functional code once, with a scan of the chain it selects
      for (int c = 0; c < 8; c++) begin
         code = c[2:0];
         // the tester never loads a reserved code
         if (code inside {3'h3, 3'h5, 3'h6}) continue;
         ir(code);
         check(96'(instr_o), 96'(code));
         check(96'(extest_o), 96'(code == 3'h0));
         check(96'(q_bus_en_o), 96'(code != 3'h2));
         d     = {$urandom, $urandom, $urandom};
         d[88] = 1'b1;
         case (code)
            3'h0, 3'h2, 3'h4: dr(89, d, {8'h01, pat});
            3'h1:             dr(32, d, 96'(ID));
            default:          dr(8, d, 96'({d[6:0], 1'b0}));
         endcase
         if (code == 3'h0 || code == 3'h4)
            check(96'(pin_drive_o), 96'(d[87:0]));
      end
      // fill the snapshot fifo until it refuses
      ir(3'h4);
      d = {$urandom, $urandom, $urandom};
      snap_valid_i <= 1'b1;
      snap_data_i  <= d[87:0];
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (snap_ready_o === 1'b1) begin
            wq.push_back(snap_data_i);
            d = {$urandom, $urandom, $urandom};
            snap_data_i <= d[87:0];
         end
      end
      snap_valid_i <= 1'b0;
      check(96'(wq.size()), 96'd8);
      // drain by sample captures while a new preload shifts in
      c89 = 1'b1;
      for (int i = 0; i < 8; i++) begin
         d     = {$urandom, $urandom, $urandom};
         d[88] = (i != 7);
         dr(89, d, {7'h0, c89, wq.pop_front()});
         c89 = d[88];
         check(96'(pin_drive_o), 96'(d[87:0]));
         check(96'(snap_ready_o), 96'h1);
      end
      check(96'(q_bus_en_o), 96'h1);
      // a push offered while the enable is low must not be stored;
      // the capture below then shows the later live word instead
      d = {$urandom, $urandom, $urandom};
      ce_i         <= 1'b0;
      snap_valid_i <= 1'b1;
      snap_data_i  <= d[87:0];
      repeat (3) @(posedge clk_i);
      d = {$urandom, $urandom, $urandom};
      ce_i         <= 1'b1;
      snap_valid_i <= 1'b0;
      snap_data_i  <= d[87:0];
      @(posedge clk_i);
      // cleared enable cell floats the bus once external test is set
      ir(3'h0);
      check(96'(extest_o), 96'h1);
      check(96'(q_bus_en_o), 96'h0);
      d     = {$urandom, $urandom, $urandom};
      d[88] = 1'b1;
      dr(89, d, {8'h00, snap_data_i});
      check(96'(q_bus_en_o), 96'h1);
      check(96'(pin_drive_o), 96'(d[87:0]));
      i_ctl.reset_tap();
      repeat (2) @(posedge clk_i);
      idle_checks();
      check(96'(exp_q.size()), 96'h0);
      finish_test();
   end

endmodule : boundary_scan_instruction_logic_bench
